// ===== core/bocr_pkg.sv
package bocr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam int BOCR_ADDR_W = 8;
  localparam int BOCR_DATA_W = 24;
  localparam logic [7:0] BOCR_BRIDGE_CFG_IDX = 8'h39;
  localparam logic [7:0] BOCR_RECOV_MON_IDX = 8'h3A;
  localparam logic [7:0] BOCR_SRC_SEL_A_IDX = 8'h3B;
  // Bridge driver config fields
  localparam int BOCR_DSM_THR_LSB = 21;
  localparam int BOCR_DECAY_SIDE_BIT = 14;
  localparam int BOCR_DECAY_SINGLE_BIT = 13;
  localparam int BOCR_DUAL_MOTOR_BIT = 12;
  localparam int BOCR_DEAD_TIME_LSB = 8;
  localparam int BOCR_OL_THR_BIT = 7;
  localparam int BOCR_OL_TEST_A_BIT = 6;
  localparam int BOCR_OL_TEST_B_BIT = 5;
  localparam int BOCR_SLEW_LSB = 0;
  // Writable masks, reserved bits read zero
  localparam logic [23:0] BOCR_BRIDGE_CFG_MASK = 24'h607FFF;
  localparam logic [23:0] BOCR_RECOV_MON_MASK = 24'h81F83F;
  localparam logic [23:0] BOCR_SRC_SEL_A_MASK = 24'h00FFFF;
  // Reset values
  localparam logic [23:0] BOCR_BRIDGE_CFG_RST = 24'h600F00;
  localparam logic [23:0] BOCR_RECOV_MON_RST = 24'h000020;
  localparam logic [23:0] BOCR_SRC_SEL_A_RST = 24'h000000;
  // Recovery and monitor fields
  localparam int BOCR_RDSON_BIT = 23;
  localparam int BOCR_RECOV_LSB = 11;
  localparam int BOCR_MON_EN_BIT = 5;
  localparam int BOCR_MON_SEL_LSB = 0;
  localparam logic [4:0] BOCR_MON_FIRST = 5'h04;
  localparam logic [4:0] BOCR_MON_LAST = 5'h10;
  localparam logic [4:0] BOCR_MON_HOLE = 5'h0A;
  // Output source codes
  localparam logic [3:0] BOCR_SRC_OFF = 4'h0;
  localparam logic [3:0] BOCR_SRC_ON = 4'h1;
  localparam logic [3:0] BOCR_SRC_TMR1 = 4'h2;
  localparam logic [3:0] BOCR_SRC_TMR2 = 4'h3;
  localparam logic [3:0] BOCR_SRC_PWM1 = 4'h4;
  localparam logic [3:0] BOCR_SRC_DIRECTION_SIGNAL_ONE = 4'hE;
  localparam logic [3:0] BOCR_SRC_DIRECTION_SIGNAL_TWO = 4'hF;
  // Timing
  localparam int BOCR_CLK_MHZ = 100;
  localparam int BOCR_DT_STEP_NS = 50;
  localparam int BOCR_DT_STEP_CYC = (BOCR_DT_STEP_NS * BOCR_CLK_MHZ + 999) / 1000;
  localparam int BOCR_PWM_BITS = 10;
  localparam int BOCR_PWM_PERIOD = 1024;
endpackage

// ===== core/bocr_pwm_chan.sv
`timescale 1ns/1ps
module bocr_pwm_chan
  import bocr_pkg::*;
#(
  parameter int DUTY_W = BOCR_PWM_BITS
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [DUTY_W-1:0] pwm_duty_code_i,
  output logic pwm_o
);
  // ****************************************
  // Free-running period counter
  // ****************************************
  logic [DUTY_W-1:0] cnt_reg;
  logic [DUTY_W-1:0] cnt_next;
  logic pwm_reg;
  logic pwm_next;

  // Duty is code/1024, code zero never turns on
  always_comb
  begin
    cnt_next = cnt_reg + 1'b1;
    pwm_next = (cnt_reg < pwm_duty_code_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= '0;
      pwm_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pwm_reg <= pwm_next;
    end
  end

  assign pwm_o = pwm_reg;
endmodule

// ===== core/bocr_leg_guard.sv
`timescale 1ns/1ps
module bocr_leg_guard
  import bocr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hs_req_i,
  input wire logic ls_req_i,
  input wire logic [3:0] dead_code_i,
  output logic hs_on_o,
  output logic ls_on_o
);
  // ****************************************
  // Break-before-make with dead time
  // ****************************************
  logic hs_reg;
  logic hs_next;
  logic ls_reg;
  logic ls_next;
  logic [11:0] dt_reg;
  logic [11:0] dt_next;

  // Dead time counts code times one step; both off while it runs
  always_comb
  begin
    hs_next = hs_reg;
    ls_next = ls_reg;
    dt_next = dt_reg;
    if (dt_reg != 12'h000)
    begin
      dt_next = dt_reg - 12'h001;
    end
    else if (hs_reg && !hs_req_i)
    begin
      // Switching off is immediate
      hs_next = 1'b0;
      dt_next = 12'(dead_code_i) * 12'(BOCR_DT_STEP_CYC);
    end
    else if (ls_reg && !ls_req_i)
    begin
      ls_next = 1'b0;
      dt_next = 12'(dead_code_i) * 12'(BOCR_DT_STEP_CYC);
    end
    else if (!hs_reg && !ls_reg)
    begin
      // Never both on; high side wins a conflicting request
      hs_next = hs_req_i;
      ls_next = ls_req_i && !hs_req_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_reg <= 1'b0;
      ls_reg <= 1'b0;
      dt_reg <= 12'h000;
    end
    else
    begin
      hs_reg <= hs_next;
      ls_reg <= ls_next;
      dt_reg <= dt_next;
    end
  end

  assign hs_on_o = hs_reg;
  assign ls_on_o = ls_reg;
endmodule

// ===== core/bocr_regs.sv
`timescale 1ns/1ps
module bocr_regs
  import bocr_pkg::*;
#(
  parameter int PWM_CH = 10
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [BOCR_ADDR_W-1:0] addr_i,
  input wire logic [BOCR_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [BOCR_DATA_W-1:0] rdata_o,
  input wire logic bridge_direction_pin_i,
  input wire logic bridge_decay_i,
  input wire logic [PWM_CH*BOCR_PWM_BITS-1:0] pwm_duty_code_i,
  input wire logic timer_one_i,
  input wire logic timer_two_i,
  input wire logic direction_signal_one_i,
  input wire logic direction_signal_two_i,
  output logic [1:0] ds_monitor_threshold_o,
  output logic dual_motor_select_o,
  output logic [3:0] crossover_dead_time_o,
  output logic openload_threshold_high_o,
  output logic openload_test_a_o,
  output logic openload_test_b_o,
  output logic [4:0] slew_code_o,
  output logic output7_resistance_select_o,
  output logic [5:0] recovery_enable_o,
  output logic current_monitor_enable_o,
  output logic [4:0] current_monitor_select_o,
  output logic bridge_hs1_o,
  output logic bridge_ls1_o,
  output logic bridge_hs2_o,
  output logic bridge_ls2_o,
  output logic [3:0] hs_out_o
);
  // ****************************************
  // Register storage
  // ****************************************
  // Three control words; reserved bits are never stored
  logic [23:0] bridge_driver_config_reg;
  logic [23:0] bridge_driver_config_next;
  logic [23:0] recovery_and_monitor_config_reg;
  logic [23:0] recovery_and_monitor_config_next;
  logic [23:0] output_source_select_a_reg;
  logic [23:0] output_source_select_a_next;
  logic [23:0] rdata_reg;
  logic [23:0] rdata_next;

  // Masked merge keeps reserved bits at zero
  // so software always reads them back as zero
  function automatic logic [23:0] merge(input logic [23:0] d, input logic [23:0] m);
    merge = d & m;
  endfunction

  // Decoded source level for one four-bit field
  // Codes 4 to 13 pick a PWM level, first channel at bit 0
  // Each field uses the same table, so one function serves all four
  function automatic logic src_level(input logic [3:0] code, input logic t1, input logic t2,
                                     input logic d1, input logic d2, input logic [9:0] pw);
    logic lvl;
    lvl = 1'b0;
    case (code)
      BOCR_SRC_OFF: lvl = 1'b0;
      BOCR_SRC_ON: lvl = 1'b1;
      BOCR_SRC_TMR1: lvl = t1;
      BOCR_SRC_TMR2: lvl = t2;
      BOCR_SRC_DIRECTION_SIGNAL_ONE: lvl = d1;
      BOCR_SRC_DIRECTION_SIGNAL_TWO: lvl = d2;
      default: lvl = pw[4'(code - BOCR_SRC_PWM1)];
    endcase
    src_level = lvl;
  endfunction

  // Write decode; unmapped addresses are ignored
  // Dead-time codes 0000 and 0001 are stored as written; keep them out
  always_comb
  begin
    bridge_driver_config_next = bridge_driver_config_reg;
    recovery_and_monitor_config_next = recovery_and_monitor_config_reg;
    output_source_select_a_next = output_source_select_a_reg;
    if (wr_i)
    begin
      case (addr_i)
        BOCR_BRIDGE_CFG_IDX: bridge_driver_config_next = merge(wdata_i, BOCR_BRIDGE_CFG_MASK);
        BOCR_RECOV_MON_IDX: recovery_and_monitor_config_next = merge(wdata_i, BOCR_RECOV_MON_MASK);
        BOCR_SRC_SEL_A_IDX:
          output_source_select_a_next = merge(wdata_i, BOCR_SRC_SEL_A_MASK);
        default: ;
      endcase
    end
  end

  // Read data valid the cycle after the strobe; zero otherwise
  // Zero outside a read keeps the bus quiet between accesses
  // Reads and writes may come back to back with no gap
  always_comb
  begin
    rdata_next = 24'h000000;
    if (rd_i)
    begin
      case (addr_i)
        BOCR_BRIDGE_CFG_IDX: rdata_next = bridge_driver_config_reg;
        BOCR_RECOV_MON_IDX: rdata_next = recovery_and_monitor_config_reg;
        BOCR_SRC_SEL_A_IDX: rdata_next = output_source_select_a_reg;
        default: rdata_next = 24'h000000;
      endcase
    end
  end

  // Register bank; reset loads the default words
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bridge_driver_config_reg <= BOCR_BRIDGE_CFG_RST;
      recovery_and_monitor_config_reg <= BOCR_RECOV_MON_RST;
      output_source_select_a_reg <= BOCR_SRC_SEL_A_RST;
      rdata_reg <= 24'h000000;
    end
    else
    begin
      bridge_driver_config_reg <= bridge_driver_config_next;
      recovery_and_monitor_config_reg <= recovery_and_monitor_config_next;
      output_source_select_a_reg <= output_source_select_a_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************
  // PWM channels and source decode
  // ****************************************
  // PWM levels, decoded source levels and their register
  logic [PWM_CH-1:0] pwm_lvl;
  logic [3:0] hs_reg;
  logic [3:0] hs_next;

  // Channels run free; their phase is not tied to a write
  // Trade-off: a duty change lands mid period, with no glitch guard
  genvar g;
  generate
    for (g = 0; g < PWM_CH; g++)
    begin : g_pwm
      bocr_pwm_chan #(.DUTY_W(BOCR_PWM_BITS)) u_pwm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pwm_duty_code_i(pwm_duty_code_i[g*BOCR_PWM_BITS +: BOCR_PWM_BITS]),
        .pwm_o(pwm_lvl[g])
      );
    end
  endgenerate

  // Four driver fields at 3:0, 7:4, 11:8, 15:12
  // Each output lags its source by one register stage
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      hs_next[i] = src_level(output_source_select_a_reg[4*i +: 4], timer_one_i, timer_two_i,
                             direction_signal_one_i, direction_signal_two_i,
                             pwm_lvl);
    end
  end

  // ****************************************
  // Current monitor and config outputs
  // ****************************************
  // Monitor enable register and a view of the select field
  logic mon_en_reg;
  logic mon_en_next;
  logic [4:0] mon_sel;

  // Unknown codes deactivate the monitor
  // Enable and select are both checked, so the pin never shows a
  // stale image after software clears the enable
  always_comb
  begin
    mon_sel = recovery_and_monitor_config_reg[BOCR_MON_SEL_LSB +: 5];
    mon_en_next = recovery_and_monitor_config_reg[BOCR_MON_EN_BIT]
                  && (mon_sel >= BOCR_MON_FIRST) && (mon_sel <= BOCR_MON_LAST)
                  && (mon_sel != BOCR_MON_HOLE);
  end

  // Decoded levels and monitor enable registered for clean pins
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      // Monitor stays off until the first decode after reset
      hs_reg <= 4'h0;
      mon_en_reg <= 1'b0;
    end
    else
    begin
      hs_reg <= hs_next;
      mon_en_reg <= mon_en_next;
    end
  end

  // ****************************************
  // Bridge leg requests
  // ****************************************
  // Requests ahead of the dead-time guards
  logic dir;
  logic hs_side;
  logic single;
  logic [1:0] hs_req;
  logic [1:0] ls_req;

  // Drive forward/reverse, or slow decay on chosen side
  // Drive phase: one high switch and the opposite low switch
  // Slow decay: both legs on the chosen side, or one leg by direction
  always_comb
  begin
    dir = bridge_direction_pin_i;
    hs_side = bridge_driver_config_reg[BOCR_DECAY_SIDE_BIT];
    single = bridge_driver_config_reg[BOCR_DECAY_SINGLE_BIT];
    hs_req = 2'b00;
    ls_req = 2'b00;
    if (!bridge_decay_i)
    begin
      hs_req = dir ? 2'b10 : 2'b01;
      ls_req = dir ? 2'b01 : 2'b10;
    end
    else if (hs_side)
    begin
      // Single leg choice follows only the direction pin
      hs_req = single ? (dir ? 2'b10 : 2'b01) : 2'b11;
    end
    else
    begin
      ls_req = single ? (dir ? 2'b10 : 2'b01) : 2'b11;
    end
  end

  // Guarded switch states, one bit per leg
  logic [1:0] hs_on;
  logic [1:0] ls_on;

  // One guard per half bridge, each with its own dead-time counter
  // Both guards read the same dead-time field
  generate
    for (g = 0; g < 2; g++)
    begin : g_leg
      bocr_leg_guard u_guard (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .hs_req_i(hs_req[g]),
        .ls_req_i(ls_req[g]),
        .dead_code_i(bridge_driver_config_reg[BOCR_DEAD_TIME_LSB +: 4]),
        .hs_on_o(hs_on[g]),
        .ls_on_o(ls_on[g])
      );
    end
  endgenerate

  // ****************************************
  // Output assignments (all registered)
  // ****************************************
  // Config outputs are plain register bits: they change one cycle
  // after the write strobe and stay until the next write
  assign rdata_o = rdata_reg;
  assign ds_monitor_threshold_o = bridge_driver_config_reg[BOCR_DSM_THR_LSB +: 2];
  assign dual_motor_select_o = bridge_driver_config_reg[BOCR_DUAL_MOTOR_BIT];
  assign crossover_dead_time_o = bridge_driver_config_reg[BOCR_DEAD_TIME_LSB +: 4];
  assign openload_threshold_high_o = bridge_driver_config_reg[BOCR_OL_THR_BIT];
  assign openload_test_a_o = bridge_driver_config_reg[BOCR_OL_TEST_A_BIT];
  assign openload_test_b_o = bridge_driver_config_reg[BOCR_OL_TEST_B_BIT];
  assign slew_code_o = bridge_driver_config_reg[BOCR_SLEW_LSB +: 5];
  assign output7_resistance_select_o = recovery_and_monitor_config_reg[BOCR_RDSON_BIT];
  assign recovery_enable_o = recovery_and_monitor_config_reg[BOCR_RECOV_LSB +: 6];
  assign current_monitor_enable_o = mon_en_reg;
  assign current_monitor_select_o = recovery_and_monitor_config_reg[BOCR_MON_SEL_LSB +: 5];
  assign bridge_hs1_o = hs_on[0];
  assign bridge_ls1_o = ls_on[0];
  assign bridge_hs2_o = hs_on[1];
  assign bridge_ls2_o = ls_on[1];
  assign hs_out_o = hs_reg;
endmodule

// ===== verification/bocr_regs_sva.sv
`timescale 1ns/1ps
// ****************************************
// Port checker for the register bank
// ****************************************
module bocr_regs_chk
  import bocr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [23:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [23:0] rdata_o,
  input wire logic direction_signal_one_i,
  input wire logic [1:0] ds_monitor_threshold_o,
  input wire logic [3:0] crossover_dead_time_o,
  input wire logic openload_test_a_o,
  input wire logic openload_test_b_o,
  input wire logic [4:0] slew_code_o,
  input wire logic current_monitor_enable_o,
  input wire logic [4:0] current_monitor_select_o,
  input wire logic bridge_hs1_o,
  input wire logic bridge_ls1_o,
  input wire logic bridge_hs2_o,
  input wire logic bridge_ls2_o,
  input wire logic [3:0] hs_out_o
);
  logic [23:0] wd_q; // Write data bus of last cycle, sampled whether or not it was a write
  logic cfg_q; // Bridge config written last cycle
  logic mon_q; // Mirror of monitor enable bit
  logic [15:0] src_q; // Mirror of source fields
  logic mon_ok; // Monitor should drive its pin
  logic [3:0] off_m; // Fields coded off
  logic [3:0] on_m; // Fields coded on
  logic [3:0] d1_m; // Fields following direction one
  // Mirrors kept apart from the design, so a stuck register shows
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wd_q <= '0;
      cfg_q <= 1'b0;
      mon_q <= 1'b1;
      src_q <= '0;
    end
    else
    begin
      wd_q <= wdata_i;
      cfg_q <= wr_i && addr_i == BOCR_BRIDGE_CFG_IDX;
      if (wr_i && addr_i == BOCR_RECOV_MON_IDX)
        mon_q <= wdata_i[5];
      if (wr_i && addr_i == BOCR_SRC_SEL_A_IDX)
        src_q <= wdata_i[15:0];
    end
  end
  // Decoded views of the mirrors
  always_comb
  begin
    mon_ok = mon_q && current_monitor_select_o >= BOCR_MON_FIRST
      && current_monitor_select_o <= BOCR_MON_LAST && current_monitor_select_o != BOCR_MON_HOLE;
    for (int i = 0; i < 4; i++)
    begin
      off_m[i] = src_q[4*i+:4] == BOCR_SRC_OFF;
      on_m[i] = src_q[4*i+:4] == BOCR_SRC_ON;
      d1_m[i] = src_q[4*i+:4] == BOCR_SRC_DIRECTION_SIGNAL_ONE;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_thr_follows: assert property (cfg_q |-> ds_monitor_threshold_o == wd_q[22:21])
    else $error("threshold differs from write");
  chk_dead_follows: assert property (cfg_q |-> crossover_dead_time_o == wd_q[11:8])
    else $error("dead time differs from write");
  chk_test_slew: assert property (cfg_q |->
    {openload_test_a_o, openload_test_b_o, slew_code_o} == wd_q[6:0])
    else $error("pull-up or slew differs from write");
  chk_mon_enable: assert property (1 |=> current_monitor_enable_o == $past(mon_ok))
    else $error("monitor enable wrong");
  chk_mon_hole: assert property (current_monitor_select_o == BOCR_MON_HOLE
    || current_monitor_select_o > BOCR_MON_LAST |=> !current_monitor_enable_o)
    else $error("monitor on for missing output");
  chk_src_fixed: assert property ((hs_out_o & $past(off_m)) == 4'h0
    && (~hs_out_o & $past(on_m)) == 4'h0)
    else $error("fixed source decode wrong");
  chk_src_dir: assert property (((hs_out_o ^ {4{$past(direction_signal_one_i)}})
    & $past(d1_m)) == 4'h0)
    else $error("output not following direction");
  chk_legs_apart: assert property (!(bridge_hs1_o && bridge_ls1_o) && !(bridge_hs2_o && bridge_ls2_o))
    else $error("both switches of a leg on");
  chk_src_read: assert property ($past(rd_i) && $past(addr_i) == BOCR_SRC_SEL_A_IDX
    |-> rdata_o == {8'h00, src_q})
    else $error("source register read wrong");
endmodule
bind bocr_regs bocr_regs_chk chk_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .direction_signal_one_i, .ds_monitor_threshold_o, .crossover_dead_time_o, .openload_test_a_o,
  .openload_test_b_o, .slew_code_o, .current_monitor_enable_o, .current_monitor_select_o,
  .bridge_hs1_o, .bridge_ls1_o, .bridge_hs2_o, .bridge_ls2_o, .hs_out_o);

// ===== verification/bocr_bridge_model.sv
`timescale 1ns/1ps
// ****************************************
// External H-bridge switches
// ****************************************
module bocr_bridge_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] gate_i, // High one, low one, high two, low two
  output logic fault_o
);
  // Sticky, so a single-cycle overlap is not lost
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      fault_o <= 1'b0;
    else if (gate_i[3:2] == 2'b11 || gate_i[1:0] == 2'b11)
      fault_o <= 1'b1;
  end
endmodule

// ===== verification/tb_bocr_regs.sv
`timescale 1ns/1ps
module tb_bocr_regs
  import bocr_pkg::*;
;
  logic clk_i = 0;
  logic rst_i = 1;
  logic [7:0] addr_i = '0;
  logic [23:0] wdata_i = '0;
  logic wr_i = 0;
  logic rd_i = 0;
  logic dir_pin = 0;
  logic decay = 0;
  logic [99:0] duty = '0;
  logic [3:0] lv = '0; // Timer one, timer two, direction one, direction two
  logic [23:0] rdata_o;
  logic [1:0] ds_monitor_threshold_o;
  logic [3:0] crossover_dead_time_o;
  logic openload_test_a_o;
  logic openload_test_b_o;
  logic [4:0] slew_code_o;
  logic current_monitor_enable_o;
  logic [4:0] current_monitor_select_o;
  logic bridge_hs1_o;
  logic bridge_ls1_o;
  logic bridge_hs2_o;
  logic bridge_ls2_o;
  logic [3:0] hs_out_o;
  logic dual_motor_select_o;
  logic openload_threshold_high_o;
  logic output7_resistance_select_o;
  logic [5:0] recovery_enable_o;
  logic direction_signal_one_i;
  logic fault;
  logic [23:0] got;
  logic [3:0] k;
  int n;
  int err_total = 0;
  int check_count = 0;
  // Write, expected readback; no forbidden dead-time code is used
  logic [55:0] rows [8] = '{56'h39FFFFFF607FFF, 56'h39000200000200, 56'h3AFFFFFF81F83F,
    56'h3A000025000025, 56'h3BFFFFFF00FFFF, 56'h3B00E21300E213, 56'h40FFFFFF000000,
    56'h38123456000000};
  // Decay side, single leg, direction, decay phase, then hs1 ls1 hs2 ls2
  logic [7:0] br [8] = '{8'h09, 8'h26, 8'h15, 8'hBA, 8'h54, 8'h71, 8'hD8, 8'hF2};
  assign direction_signal_one_i = lv[1];
  bocr_regs dut_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .bridge_direction_pin_i(dir_pin), .bridge_decay_i(decay), .pwm_duty_code_i(duty),
    .timer_one_i(lv[3]), .timer_two_i(lv[2]), .direction_signal_one_i,
    .direction_signal_two_i(lv[0]), .ds_monitor_threshold_o, .dual_motor_select_o,
    .crossover_dead_time_o, .openload_threshold_high_o, .openload_test_a_o,
    .openload_test_b_o, .slew_code_o, .output7_resistance_select_o, .recovery_enable_o,
    .current_monitor_enable_o, .current_monitor_select_o, .bridge_hs1_o, .bridge_ls1_o,
    .bridge_hs2_o, .bridge_ls2_o, .hs_out_o);
  bocr_bridge_model mdl_u (.clk_i, .rst_i,
    .gate_i({bridge_hs1_o, bridge_ls1_o, bridge_hs2_o, bridge_ls2_o}), .fault_o(fault));
  // ****************************************
  // Clock and bus tasks
  // ****************************************
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge clk_i);
    wr_i <= 0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [23:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge clk_i);
    rd_i <= 0;
    #1;
    d = rdata_o;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 0;
    rd_reg(BOCR_BRIDGE_CFG_IDX, got);
    chk(got, 24'h600F00);
    rd_reg(BOCR_RECOV_MON_IDX, got);
    chk(got, 24'h000020);
    rd_reg(BOCR_SRC_SEL_A_IDX, got);
    chk(got, 24'h000000);
    chk(24'({ds_monitor_threshold_o, crossover_dead_time_o, current_monitor_enable_o,
      hs_out_o}), 24'h0007E0);
    chk(24'({output7_resistance_select_o, recovery_enable_o}), 24'h000000);
    chk(24'({dual_motor_select_o, openload_threshold_high_o}), 24'h000000);
    $display("test reset done");
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(rows[i][55:48], rows[i][47:24]);
      rd_reg(rows[i][55:48], got);
      chk(got, rows[i][23:0]);
    end
    $display("test register rows done");
    // Single fields land on their own outputs one cycle after the write
    wr_reg(BOCR_RECOV_MON_IDX, 24'h81A800);
    wr_reg(BOCR_BRIDGE_CFG_IDX, 24'h601F80);
    #1;
    chk(24'({output7_resistance_select_o, recovery_enable_o}), 24'h000075);
    chk(24'({dual_motor_select_o, openload_threshold_high_o}), 24'h000003);
    $display("test field outputs done");
    // Every select code, then the enable bit cleared on a real output
    for (int c = 0; c < 33; c++)
    begin
      wr_reg(BOCR_RECOV_MON_IDX, (c < 32) ? 24'h000020 | 24'(c) : 24'h000004);
      @(posedge clk_i);
      #1;
      chk(24'(current_monitor_enable_o), 24'(c >= 4 && c <= 16 && c != 10));
    end
    $display("test monitor select done");
    // Every source code with both level sets of the source signals
    for (int p = 0; p < 2; p++)
    begin
      @(posedge clk_i);
      lv <= p ? 4'h5 : 4'hA;
      for (int i = 0; i < 16; i++)
      begin
        k = i[3:0];
        wr_reg(BOCR_SRC_SEL_A_IDX, {8'h00, {4{k}}});
        repeat (2) @(posedge clk_i);
        #1;
        chk(24'(hs_out_o), {20'h0, {4{k == 1 || (k == 2 && lv[3]) || (k == 3 && lv[2])
          || (k == 14 && lv[1]) || (k == 15 && lv[0])}}});
      end
    end
    $display("test source decode done");
    @(posedge clk_i);
    duty <= {10{10'h155}};
    wr_reg(BOCR_SRC_SEL_A_IDX, 24'h000004);
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (BOCR_PWM_PERIOD)
    begin
      @(posedge clk_i);
      #1;
      n += int'(hs_out_o[0] === 1'b1);
    end
    chk(24'(n), 24'h000155);
    $display("test pwm duty done");
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(BOCR_BRIDGE_CFG_IDX, 24'h600200 | (24'(br[i][7:6]) << 13));
      dir_pin <= br[i][5];
      decay <= br[i][4];
      repeat (40) @(posedge clk_i);
      #1;
      chk({bridge_hs1_o, bridge_ls1_o, bridge_hs2_o, bridge_ls2_o}, 24'(br[i][3:0]));
    end
    $display("test bridge legs done");
    // Direction reversal waits out the dead time; shortest and longest codes
    for (int i = 0; i < 2; i++)
    begin
      k = i ? 4'hF : 4'h2;
      wr_reg(BOCR_BRIDGE_CFG_IDX, 24'h600000 | (24'(k) << 8));
      dir_pin <= 0;
      decay <= 0;
      repeat (120) @(posedge clk_i);
      dir_pin <= 1;
      n = 0;
      while (bridge_ls1_o !== 1'b1 && n < 200)
      begin
        @(posedge clk_i);
        #1;
        n++;
      end
      // A stuck leg counts twice, here and in the check below; the run carries on to the report
      if (n == 200)
      begin
        err_total++;
      end
      chk(24'(n >= k * BOCR_DT_STEP_CYC && n <= k * BOCR_DT_STEP_CYC + 4), 24'h000001);
    end
    chk(24'(fault), 24'h000000);
    $display("test dead time done");
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd_reg(BOCR_BRIDGE_CFG_IDX, got);
    chk(got, 24'h600F00);
    $display("test second reset done");
    final_report();
  end
endmodule
